// ---- pbc_pkg.sv ----
package pbc_pkg;

  // ----------------------------------------------------------------
  // Register map and bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFF_OPERATING_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_LIMIT_CONFIG = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STATUS_COMMAND = 4'h8;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] checked_bit_count;
    logic [1:0] baud_range;
    logic sleep_extend_bit;
    logic [4:0] sleep;
  } pbc_op_cfg_s;

  typedef struct packed {
    logic [4:0] upper_window_count;
    logic [4:0] lower_window_count;
  } pbc_lim_cfg_s;

  localparam int OP_CFG_W = 10;
  localparam int LIM_CFG_W = 10;
  localparam int CMD_RETURN_POLL_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam pbc_op_cfg_s OP_CFG_RESET = 10'h000;
  localparam pbc_lim_cfg_s LIM_CFG_RESET = 10'h000;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int BASE_DIV_HIGH_BAND = 28;
  localparam int BASE_DIV_LOW_BAND = 30;
  localparam int SLEEP_UNIT_SHIFT = 10;
  localparam int SLEEP_EXT_SHIFT = 3;
  localparam logic [4:0] SLEEP_PERMANENT = 5'h1f;
  localparam int EDGES_PER_BIT_STEP = 6;
  localparam int STARTUP_TICKS_DEFAULT = 16;
  localparam int SLEEP_CNT_W = 18;

  // ----------------------------------------------------------------
  // Polling states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    pbc_st_sleep = 4'h1,
    pbc_st_startup = 4'h2,
    pbc_st_check = 4'h4,
    pbc_st_receive = 4'h8
  } pbc_state_e;

endpackage

// ---- pbc_tick_gen.sv ----
`timescale 1ns/1ps
module pbc_tick_gen #(
  parameter bit LOW_BAND = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Rate select
  input wire logic [1:0] baud_range,
  // Tick pulses
  output logic base_tick,
  output logic extended_tick
);

  localparam int DIV = LOW_BAND ? pbc_pkg::BASE_DIV_LOW_BAND : pbc_pkg::BASE_DIV_HIGH_BAND;
  localparam logic [4:0] DIV_LAST = 5'(DIV - 1);

  logic [4:0] div_q, div_d;
  logic [2:0] ext_q, ext_d;
  logic base_d, xt_d;
  logic [2:0] mask;

  // ----------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------
  always_comb begin
    div_d = (div_q == DIV_LAST) ? 5'h00 : div_q + 5'h01;
    base_d = (div_q == DIV_LAST);
    unique case (baud_range)
      2'h0: mask = 3'h7;
      2'h1: mask = 3'h3;
      2'h2: mask = 3'h1;
      default: mask = 3'h0;
    endcase
    ext_d = base_d ? ext_q + 3'h1 : ext_q;
    xt_d = base_d && ((ext_q & mask) == mask);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      div_q <= 5'h00;
      ext_q <= 3'h0;
      base_tick <= 1'b0;
      extended_tick <= 1'b0;
    end else begin
      div_q <= div_d;
      ext_q <= ext_d;
      base_tick <= base_d;
      extended_tick <= xt_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_base_gap;
    @(posedge clock) disable iff (reset) base_tick |=> !base_tick [*8];
  endproperty
  a_base_gap: assert property (p_base_gap) else $error("base tick too frequent");

  property p_ext_on_base;
    @(posedge clock) disable iff (reset) extended_tick |-> base_tick;
  endproperty
  a_ext_on_base: assert property (p_ext_on_base) else $error("extended tick off base tick");

endmodule

// ---- pbc_controller.sv ----
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// Function
// - Base tick is the oscillator clock divided by 28, or 30 for low band.
// - Extended tick spans 8, 4, 2 or 1 base ticks per baud range.
// - Polling loops sleep, start-up, bit check, back to sleep on failure.
// - Signal processing off during sleep, on from start-up onward.
// - Activity indicator output shows active versus sleeping.
// - Sleep time is sleep field times multiplier times 1024 base ticks.
// - Sleep multiplier is 8 with extend bit set, else 1.
// - Maximum sleep value holds the device asleep until reprogrammed.
// - Sleep value 31 is the permanent sleep setting.
// - Bit check tests edge distances against a window, up to a set count.
// - Checked bit count 0,3,6,9 needs 0,6,12,18 edge tests.
// - In-window edge continues; too short or too long aborts to sleep.
// - Lower bound is lower count ticks; upper is upper count minus 1.
// - Lower and upper window counts are separate 5-bit fields.
// - Bit-check counter runs on extended tick; demodulator ignored in start-up.
// - Fail when counter below lower at an edge or reaching upper.
// - After all tests pass, demodulated data goes to the data output.
// - Receiving mode holds until commanded back to polling.
// - Data output changes only on extended-tick boundaries while receiving; it is held high outside receive.
module pbc_controller #(
  parameter bit LOW_BAND = 1'b0,
  parameter int STARTUP_TICKS = pbc_pkg::STARTUP_TICKS_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [pbc_pkg::ADDR_W-1:0] address,
  input wire logic [pbc_pkg::DATA_W-1:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [pbc_pkg::DATA_W-1:0] read_data,
  // Demodulator side
  input wire logic demod_in,
  output logic signal_enable,
  // Host side
  output logic active_indicator,
  output logic data_out
);

  localparam logic [7:0] STARTUP_LAST = 8'(STARTUP_TICKS - 1);

  logic base_tick, ext_tick;
  pbc_pkg::pbc_op_cfg_s op_q, op_d;
  pbc_pkg::pbc_lim_cfg_s lim_q, lim_d;
  logic cmd_poll_q, cmd_poll_d;
  logic [pbc_pkg::DATA_W-1:0] rd_q, rd_d;
  logic sync1_q, sync2_q, sync3_q, lvl_q, lvl_d;
  logic dx_q, dx_d;
  pbc_pkg::pbc_state_e st_q, st_d;
  logic [pbc_pkg::SLEEP_CNT_W-1:0] slp_q, slp_d, slp_target;
  logic [7:0] su_q, su_d;
  logic [5:0] cnt_q, cnt_d;
  logic [4:0] pass_q, pass_d, pass_req;
  logic armed_q, armed_d;
  logic edge_seen;
  logic act_d, out_d;

  // ----------------------------------------------------------------
  // Tick generation
  // ----------------------------------------------------------------
  pbc_tick_gen #(
    .LOW_BAND(LOW_BAND)
  ) u_tick (
    .clock(clock),
    .reset(reset),
    .baud_range(op_q.baud_range),
    .base_tick(base_tick),
    .extended_tick(ext_tick)
  );

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_comb begin
    op_d = op_q;
    lim_d = lim_q;
    cmd_poll_d = 1'b0;
    rd_d = '0;
    if (write_strobe) begin
      unique case (address)
        pbc_pkg::OFF_OPERATING_CONFIG: op_d = write_data[pbc_pkg::OP_CFG_W-1:0];
        pbc_pkg::OFF_LIMIT_CONFIG: lim_d = write_data[pbc_pkg::LIM_CFG_W-1:0];
        pbc_pkg::OFF_STATUS_COMMAND: cmd_poll_d = write_data[pbc_pkg::CMD_RETURN_POLL_BIT];
        default: ;
      endcase
    end
    if (read_strobe) begin
      unique case (address)
        pbc_pkg::OFF_OPERATING_CONFIG: rd_d = {6'h00, op_q};
        pbc_pkg::OFF_LIMIT_CONFIG: rd_d = {6'h00, lim_q};
        pbc_pkg::OFF_STATUS_COMMAND: rd_d = {cnt_q, pass_q, st_q, active_indicator};
        default: rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      op_q <= pbc_pkg::OP_CFG_RESET;
      lim_q <= pbc_pkg::LIM_CFG_RESET;
      cmd_poll_q <= 1'b0;
      read_data <= '0;
    end else begin
      op_q <= op_d;
      lim_q <= lim_d;
      cmd_poll_q <= cmd_poll_d;
      read_data <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // Demodulator input
  // ----------------------------------------------------------------
  always_comb begin
    lvl_d = (sync2_q == sync3_q) ? sync3_q : lvl_q;
    dx_d = ext_tick ? lvl_q : dx_q;
    edge_seen = ext_tick && (lvl_q != dx_q);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      lvl_q <= 1'b0;
      dx_q <= 1'b0;
    end else begin
      sync1_q <= demod_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q <= lvl_d;
      dx_q <= dx_d;
    end
  end

  // ----------------------------------------------------------------
  // Polling state machine
  // ----------------------------------------------------------------
  always_comb begin
    slp_target = {op_q.sleep, 13'h0000} >> (op_q.sleep_extend_bit ? 0 : pbc_pkg::SLEEP_EXT_SHIFT);
    pass_req = 5'(op_q.checked_bit_count * pbc_pkg::EDGES_PER_BIT_STEP);
  end

  always_comb begin
    st_d = st_q;
    slp_d = slp_q;
    su_d = su_q;
    cnt_d = cnt_q;
    pass_d = pass_q;
    armed_d = armed_q;
    unique case (st_q)
      pbc_pkg::pbc_st_sleep: begin
        su_d = 8'h00;
        if (op_q.sleep != pbc_pkg::SLEEP_PERMANENT && base_tick) begin
          if (slp_q + 18'h00001 >= slp_target) begin
            slp_d = '0;
            st_d = pbc_pkg::pbc_st_startup;
          end else begin
            slp_d = slp_q + 18'h00001;
          end
        end
      end
      pbc_pkg::pbc_st_startup: begin
        cnt_d = 6'h00;
        pass_d = 5'h00;
        armed_d = 1'b0;
        if (base_tick) begin
          su_d = su_q + 8'h01;
          if (su_q == STARTUP_LAST) begin
            st_d = (pass_req == 5'h00) ? pbc_pkg::pbc_st_receive : pbc_pkg::pbc_st_check;
          end
        end
      end
      pbc_pkg::pbc_st_check: begin
        if (ext_tick) begin
          if (edge_seen) begin
            if (!armed_q) begin
              armed_d = 1'b1;
              cnt_d = 6'h00;
            end else if (cnt_q < {1'b0, lim_q.lower_window_count}) begin
              st_d = pbc_pkg::pbc_st_sleep;
            end else begin
              cnt_d = 6'h00;
              pass_d = pass_q + 5'h01;
              if (pass_q + 5'h01 >= pass_req) begin
                st_d = pbc_pkg::pbc_st_receive;
              end
            end
          end else if (cnt_q + 6'h01 >= {1'b0, lim_q.upper_window_count}) begin
            st_d = pbc_pkg::pbc_st_sleep;
          end else begin
            cnt_d = cnt_q + 6'h01;
          end
        end
      end
      pbc_pkg::pbc_st_receive: begin
        if (cmd_poll_q) begin
          st_d = pbc_pkg::pbc_st_sleep;
        end
      end
      default: st_d = pbc_pkg::pbc_st_sleep;
    endcase
    act_d = (st_d != pbc_pkg::pbc_st_sleep);
    out_d = (st_d == pbc_pkg::pbc_st_receive) ? (ext_tick ? lvl_q : data_out) : 1'b1;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= pbc_pkg::pbc_st_sleep;
      slp_q <= '0;
      su_q <= 8'h00;
      cnt_q <= 6'h00;
      pass_q <= 5'h00;
      armed_q <= 1'b0;
      active_indicator <= 1'b0;
      signal_enable <= 1'b0;
      data_out <= 1'b1;
    end else begin
      st_q <= st_d;
      slp_q <= slp_d;
      su_q <= su_d;
      cnt_q <= cnt_d;
      pass_q <= pass_d;
      armed_q <= armed_d;
      active_indicator <= act_d;
      signal_enable <= act_d;
      data_out <= out_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_sleep_off;
    @(posedge clock) disable iff (reset)
      (st_q == pbc_pkg::pbc_st_sleep) |-> !signal_enable && !active_indicator;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("processing on in sleep");

  property p_active_shown;
    @(posedge clock) disable iff (reset)
      (st_q != pbc_pkg::pbc_st_sleep) |-> active_indicator && signal_enable;
  endproperty
  a_active_shown: assert property (p_active_shown) else $error("activity not shown");

  property p_perm_sleep;
    @(posedge clock) disable iff (reset)
      (st_q == pbc_pkg::pbc_st_sleep && op_q.sleep == pbc_pkg::SLEEP_PERMANENT)
        |=> (st_q == pbc_pkg::pbc_st_sleep);
  endproperty
  a_perm_sleep: assert property (p_perm_sleep) else $error("left permanent sleep");

  property p_short_fail;
    @(posedge clock) disable iff (reset)
      (st_q == pbc_pkg::pbc_st_check && edge_seen && armed_q && cnt_q < {1'b0, lim_q.lower_window_count})
        |=> (st_q == pbc_pkg::pbc_st_sleep) ##1 !active_indicator;
  endproperty
  a_short_fail: assert property (p_short_fail) else $error("short edge not rejected");

  property p_long_fail;
    @(posedge clock) disable iff (reset)
      (st_q == pbc_pkg::pbc_st_check && ext_tick && !edge_seen && cnt_q + 6'h01 >= {1'b0, lim_q.upper_window_count})
        |=> (st_q == pbc_pkg::pbc_st_sleep);
  endproperty
  a_long_fail: assert property (p_long_fail) else $error("long interval not rejected");

  property p_hold_receive;
    @(posedge clock) disable iff (reset)
      (st_q == pbc_pkg::pbc_st_receive && !cmd_poll_q) |=> (st_q == pbc_pkg::pbc_st_receive);
  endproperty
  a_hold_receive: assert property (p_hold_receive) else $error("receive left without command");

  property p_data_on_tick;
    @(posedge clock) disable iff (reset)
      $changed(data_out) && $past(st_q == pbc_pkg::pbc_st_receive) && (st_q == pbc_pkg::pbc_st_receive)
        |-> $past(ext_tick);
  endproperty
  a_data_on_tick: assert property (p_data_on_tick) else $error("data changed off tick");

  property p_check_clear;
    @(posedge clock) disable iff (reset)
      $rose(st_q == pbc_pkg::pbc_st_check) |-> (cnt_q == 6'h00) && (pass_q == 5'h00) && !armed_q;
  endproperty
  a_check_clear: assert property (p_check_clear) else $error("counter not cleared at check");

  property p_reset_sleep;
    @(posedge clock) $past(reset) |-> (st_q == pbc_pkg::pbc_st_sleep) && data_out;
  endproperty
  a_reset_sleep: assert property (p_reset_sleep) else $error("not in sleep after reset");

  property p_pass_enough;
    @(posedge clock) disable iff (reset)
      $rose(st_q == pbc_pkg::pbc_st_receive) && $past(st_q == pbc_pkg::pbc_st_check) |-> (pass_q >= pass_req);
  endproperty
  a_pass_enough: assert property (p_pass_enough) else $error("receive entered early");

  c_receive: cover property (@(posedge clock) disable iff (reset) $rose(st_q == pbc_pkg::pbc_st_receive));
  c_fail: cover property (@(posedge clock) disable iff (reset)
    $past(st_q == pbc_pkg::pbc_st_check) && st_q == pbc_pkg::pbc_st_sleep);
  c_back_poll: cover property (@(posedge clock) disable iff (reset)
    $past(st_q == pbc_pkg::pbc_st_receive) && st_q == pbc_pkg::pbc_st_sleep);

endmodule

// ---- pbc_demod_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Demodulator stand-in: a toggle every clock while unpowered, noise while settling,
// then a square wave of the requested half period in clocks
// ----------------------------------------------------------------
module pbc_demod_model #(
  parameter int NOISE_CYCLES = 40
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Receiver side
  input wire logic signal_enable,
  input wire logic [31:0] period,
  output logic demod_in,
  // Observation
  output int edge_count
);
  int tcnt;
  logic [31:0] prng_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      prng_q <= 32'h1357acef;
      demod_in <= 1'b1;
      tcnt <= 0;
      edge_count <= 0;
    end else begin
      prng_q <= {prng_q[30:0], prng_q[31] ^ prng_q[21] ^ prng_q[1] ^ prng_q[0]};
      if (!signal_enable) begin
        // Unpowered output is meaningless, so it never settles
        demod_in <= ~demod_in;
        tcnt <= 0;
        edge_count <= 0;
      end else begin
        tcnt <= tcnt + 1;
        if (tcnt < NOISE_CYCLES) begin
          demod_in <= prng_q[0];
        end else if (period != 0 && (tcnt + 1) % period == 0) begin
          demod_in <= ~demod_in;
          edge_count <= edge_count + 1;
        end
      end
    end
  end
endmodule

// ---- pbc_controller_test.sv ----
`timescale 1ns/1ps
module pbc_controller_test;
  localparam int BT = pbc_pkg::BASE_DIV_HIGH_BAND;
  localparam int SU = 2;
  logic clock, reset, write_strobe, read_strobe, demod_in, signal_enable, active_indicator, data_out;
  logic [pbc_pkg::ADDR_W-1:0] address;
  logic [pbc_pkg::DATA_W-1:0] write_data, read_data;
  logic [15:0] rd;
  logic [3:0] st;
  logic [31:0] seed;
  int period, edges, miscompares, num_checks, n, code, xt;

  pbc_controller #(.LOW_BAND(1'b0), .STARTUP_TICKS(SU)) dut (.clock(clock), .reset(reset), .address(address),
    .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .demod_in(demod_in), .signal_enable(signal_enable), .active_indicator(active_indicator), .data_out(data_out));
  pbc_demod_model #(.NOISE_CYCLES(40)) partner (.clock(clock), .reset(reset), .signal_enable(signal_enable),
    .period(period), .demod_in(demod_in), .edge_count(edges));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic logic [15:0] op_word(input int c, input logic [4:0] slp, input logic ext);
    return {6'h00, 2'(c), 2'h3, ext, slp};
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask

  task automatic rdreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 d = read_data;
  endtask

  task automatic get_state(output logic [3:0] s);
    rdreg(pbc_pkg::OFF_STATUS_COMMAND, rd);
    s = rd[4:1];
    check("status activity bit", 16'(rd[0]), 16'(rd[4:1] != 4'h1));
  endtask

  task automatic wait_enable(input logic lvl, input int bound, output int cyc);
    cyc = 0;
    do begin
      @(posedge clock);
      cyc++;
      check("activity follows enable", 16'(active_indicator), 16'(signal_enable));
    end while (signal_enable !== lvl && cyc < bound);
    if (signal_enable !== lvl) begin
      miscompares++;
      $display("BAD wait for signal_enable expected %b seen %b", lvl, signal_enable);
      stop_test();
    end
  endtask

  task automatic wait_receive(input int bound);
    int i;
    i = 0;
    do begin
      get_state(st);
      i++;
    end while (st !== 4'h8 && i < bound);
    check("reached receive", 16'(st), 16'h8);
    if (st !== 4'h8) stop_test();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    address = 4'h0;
    write_data = 16'h0000;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    period = 0;
    miscompares = 0;
    num_checks = 0;
    seed = 32'h308f67a3;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    rdreg(pbc_pkg::OFF_OPERATING_CONFIG, rd);
    check("operating_config reset", rd, 16'h0000);
    rdreg(pbc_pkg::OFF_LIMIT_CONFIG, rd);
    check("limit_config reset", rd, 16'h0000);
    wr(4'hc, 16'h03ff);
    rdreg(4'hc, rd);
    check("unmapped read", rd, 16'h0000);
    wait_enable(1'b1, 4 * BT, n);
    wait_receive(2 * SU * BT);
    $display("test reset and register map done");

    wr(pbc_pkg::OFF_OPERATING_CONFIG, op_word(0, pbc_pkg::SLEEP_PERMANENT, 1'b0));
    wr(pbc_pkg::OFF_STATUS_COMMAND, 16'h0001);
    repeat (3) @(posedge clock);
    get_state(st);
    check("state after return", 16'(st), 16'h1);
    repeat (3000) @(posedge clock);
    check("permanent sleep enable", 16'(signal_enable), 16'h0);
    check("data idle in sleep", 16'(data_out), 16'h1);
    wr(pbc_pkg::OFF_OPERATING_CONFIG, op_word(0, 5'h00, 1'b0));
    wait_enable(1'b1, 4 * BT, n);
    wait_receive(2 * SU * BT);
    $display("test permanent sleep done");

    wr(pbc_pkg::OFF_LIMIT_CONFIG, {6'h00, 5'd30, 5'd19});
    rdreg(pbc_pkg::OFF_LIMIT_CONFIG, rd);
    check("limit_config readback", rd, {6'h00, 5'd30, 5'd19});
    wr(pbc_pkg::OFF_OPERATING_CONFIG, op_word(2, 5'h1e, 1'b1));
    rdreg(pbc_pkg::OFF_OPERATING_CONFIG, rd);
    check("operating_config readback", rd, op_word(2, 5'h1e, 1'b1));
    wr(pbc_pkg::OFF_OPERATING_CONFIG, op_word(0, 5'h01, 1'b0));
    wr(pbc_pkg::OFF_STATUS_COMMAND, 16'h0001);
    wait_enable(1'b0, 10, n);
    wait_enable(1'b1, 40000, n);
    check("sleep length in window", 16'(n >= 1024 * BT - BT && n <= 1024 * BT + 2 * BT), 16'h1);
    wait_receive(2 * SU * BT);
    $display("test sleep timing done");

    for (code = 1; code <= 3; code++) begin
      seed = xorshift(seed);
      // First pass runs baud range 2, so the window is timed in double base ticks
      xt = (code == 1) ? 2 : 1;
      period <= (21 + int'(seed % 7)) * BT * xt;
      wr(pbc_pkg::OFF_OPERATING_CONFIG, op_word(code, 5'h00, 1'b0) & ((code == 1) ? 16'hffbf : 16'hffff));
      wr(pbc_pkg::OFF_STATUS_COMMAND, 16'h0001);
      wait_enable(1'b0, 10, n);
      wait_enable(1'b1, 4 * BT, n);
      wait_receive(20000);
      check("edges to receive", 16'(edges), 16'(pbc_pkg::EDGES_PER_BIT_STEP * code + 1));
      repeat (period / 2) @(posedge clock);
      check("data follows demod", 16'(data_out), 16'(demod_in));
      $display("test bit check pass done");
    end
    period <= 0;
    repeat (2000) @(posedge clock);
    get_state(st);
    check("receive holds", 16'(st), 16'h8);

    period <= 10 * BT;
    wr(pbc_pkg::OFF_OPERATING_CONFIG, op_word(1, 5'h00, 1'b0));
    wr(pbc_pkg::OFF_STATUS_COMMAND, 16'h0001);
    wait_enable(1'b0, 10, n);
    wait_enable(1'b1, 4 * BT, n);
    wait_enable(1'b0, 40 * period, n);
    check("short edges fail early", 16'(edges <= 3), 16'h1);
    $display("test short interval done");

    period <= 0;
    wait_enable(1'b1, 4 * BT, n);
    wait_enable(1'b0, 60 * BT, n);
    check("long interval fail time", 16'(n >= (SU + 27) * BT && n <= (SU + 32) * BT), 16'h1);
    wait_enable(1'b1, 4 * BT, n);
    $display("test long interval done");
    stop_test();
  end
endmodule
